// *** tsr_consts.vh ***
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// Register byte offsets
`define TSR_OFF_CH0      8'h00
`define TSR_OFF_CH1      8'h04
`define TSR_OFF_CH2      8'h08
`define TSR_OFF_CH3      8'h0c
`define TSR_OFF_STATUS   8'h10
`define TSR_OFF_MASK     8'h14
`define TSR_OFF_CONFIG   8'h18

// Status and mask field positions
`define TSR_ST_OPEN_LSB  0
`define TSR_ST_PASS      4
`define TSR_ST_W         5

// Reset values
`define TSR_MASK_RST     5'h00
`define TSR_STATUS_RST   5'h00

// Sentinel codes of a result word
`define TSR_CODE_START   16'h7ffe
`define TSR_CODE_TC_OPEN 16'h7fff
`define TSR_CODE_AN_OPEN 16'h8000

// Temperature limits, tenths of a degree
`define TSR_K_C_LO       16'hf830
`define TSR_K_C_HI       16'h32c8
`define TSR_J_C_LO       16'hfc18
`define TSR_J_C_HI       16'h2134
`define TSR_K_F_LO       16'hf448
`define TSR_K_F_HI       16'h59d8
`define TSR_J_F_LO       16'hfc18
`define TSR_J_F_HI       16'h3a98
`define TSR_HOLD_MARGIN  16'h00c8
`define TSR_F_OFFSET     16'h0140
`define TSR_F_MUL        16'h0012
`define TSR_F_DIV        16'h000a

// Analog span limits
`define TSR_AN_LO        16'hfda8
`define TSR_AN_HI        16'h3138

// Timing
`define TSR_CLK_KHZ      250000
`define TSR_PASS_MS      250
`define TSR_START_MS     1000
`define TSR_CHANNELS     4

`endif

// *** tsr_readout.v ***
`timescale 1ns/100ps
`include "tsr_consts.vh"

module tsr_readout #(
    parameter PASS_CYCLES  = `TSR_PASS_MS * `TSR_CLK_KHZ,
    parameter START_CYCLES = `TSR_START_MS * `TSR_CLK_KHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output wire        irq,
    input  wire        thermocouple_type_switch,
    input  wire        temperature_unit_switch,
    input  wire        channel2_input_type_switch,
    input  wire        channel3_input_type_switch,
    input  wire        analog_range_switch,
    output reg         conv_start,
    output reg  [1:0]  conv_chan,
    output reg         conv_analog,
    output reg         conv_type_j,
    output reg         conv_live_zero,
    input  wire        sample_valid,
    input  wire        sample_open,
    input  wire [15:0] sample_data
);

    // ****************************************
    // Timing counts
    // ****************************************
    localparam [31:0] SLOT_CYCLES = PASS_CYCLES / `TSR_CHANNELS;
    localparam [31:0] START_FULL  = START_CYCLES;
    localparam [27:0] SLOT_LAST   = SLOT_CYCLES[27:0] - 28'h0000001;
    localparam [27:0] START_LAST  = START_FULL[27:0] - 28'h0000001;

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    // ****************************************
    // Switch synchronisers and config latch
    // ****************************************
    wire [4:0] sw_pin;
    reg  [4:0] sw_meta;
    reg  [4:0] sw_sync;
    reg  [4:0] cfg;
    reg        started;
    reg [27:0] start_cnt;

    assign sw_pin = {analog_range_switch, channel3_input_type_switch,
                     channel2_input_type_switch, temperature_unit_switch,
                     thermocouple_type_switch};

    // Two flops per switch pin
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sw
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sw_meta[gi] <= 1'b0;
                    sw_sync[gi] <= 1'b0;
                end else begin
                    sw_meta[gi] <= sw_pin[gi];
                    sw_sync[gi] <= sw_meta[gi];
                end
            end
        end
    endgenerate

    wire cfg_j      = cfg[0];
    wire cfg_f      = cfg[1];
    wire cfg_an2    = cfg[2];
    wire cfg_an3    = cfg[3];
    wire cfg_live   = cfg[4];

    // Startup wait; switches are frozen when it ends, since moving them
    // while powered is not supported
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cnt <= 28'h0000000;
            started   <= 1'b0;
            cfg       <= 5'h00;
        end else if (!started) begin
            cfg       <= sw_sync;
            start_cnt <= start_cnt + 28'h0000001;
            if (start_cnt == START_LAST)
                started <= 1'b1;
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    reg [27:0] slot_cnt;
    reg        slot_tick;
    reg        state;

    // Slot divider: four slots per pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt  <= 28'h0000000;
            slot_tick <= 1'b0;
        end else if (!started) begin
            slot_cnt  <= 28'h0000000;
            slot_tick <= 1'b0;
        end else if (slot_cnt == SLOT_LAST) begin
            slot_cnt  <= 28'h0000000;
            slot_tick <= 1'b1;
        end else begin
            slot_cnt  <= slot_cnt + 28'h0000001;
            slot_tick <= 1'b0;
        end
    end

    // Mode is worked out for the channel about to start, so that it
    // changes on the same edge as conv_chan and never lags it
    wire [1:0] next_chan   = conv_chan + 2'd1;
    wire       chan_analog = (next_chan == 2'd2) ? cfg_an2 :
                             (next_chan == 2'd3) ? cfg_an3 : 1'b0;

    // One request per slot, none in the slot after a missing sample; a missing sample leaves the word unchanged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            conv_start     <= 1'b0;
            conv_chan      <= 2'd3;
            conv_analog    <= 1'b0;
            conv_type_j    <= 1'b0;
            conv_live_zero <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (slot_tick) begin
                        conv_chan   <= next_chan;
                        conv_analog <= chan_analog;
                        conv_start  <= 1'b1;
                        state       <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sample_valid || slot_tick)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
            conv_type_j    <= cfg_j;
            conv_live_zero <= cfg_live;
        end
    end

    // ****************************************
    // Sample conversion
    // ****************************************
    wire signed [21:0] s_x   = {{6{sample_data[15]}}, sample_data};
    wire signed [21:0] mul_x = {6'h00, `TSR_F_MUL};
    wire signed [21:0] div_x = {6'h00, `TSR_F_DIV};
    wire signed [21:0] off_x = {6'h00, `TSR_F_OFFSET};
    wire signed [21:0] mrg_x = {6'h00, `TSR_HOLD_MARGIN};
    wire signed [21:0] prod  = s_x * mul_x;
    wire signed [21:0] temp_f = prod / div_x + off_x;
    wire signed [21:0] temp_x = cfg_f ? temp_f : s_x;

    reg  [15:0]        lim_lo;
    reg  [15:0]        lim_hi;
    wire signed [21:0] lo_x = {{6{lim_lo[15]}}, lim_lo} - mrg_x;
    wire signed [21:0] hi_x = {{6{lim_hi[15]}}, lim_hi} + mrg_x;
    wire signed [15:0] an_s  = sample_data;
    wire signed [15:0] an_lo = `TSR_AN_LO;
    wire signed [15:0] an_hi = `TSR_AN_HI;

    reg        upd;
    reg [15:0] upd_val;
    reg        upd_open;

    // Limits follow the sensor type and the reported unit
    always @* begin
        case ({cfg_j, cfg_f})
            2'b00: begin
                lim_lo = `TSR_K_C_LO;
                lim_hi = `TSR_K_C_HI;
            end
            2'b01: begin
                lim_lo = `TSR_K_F_LO;
                lim_hi = `TSR_K_F_HI;
            end
            2'b10: begin
                lim_lo = `TSR_J_C_LO;
                lim_hi = `TSR_J_C_HI;
            end
            default: begin
                lim_lo = `TSR_J_F_LO;
                lim_hi = `TSR_J_F_HI;
            end
        endcase
    end

    // Turn a sample into a result word, or decide to hold
    always @* begin
        upd      = 1'b0;
        upd_val  = `TSR_CODE_START;
        upd_open = 1'b0;
        if (state == ST_WAIT && sample_valid) begin
            if (conv_analog) begin
                upd = 1'b1;
                if (conv_live_zero && an_s < an_lo) begin
                    upd_val  = `TSR_CODE_AN_OPEN;
                    upd_open = 1'b1;
                end else if (an_s < an_lo) begin
                    upd_val = `TSR_AN_LO;
                end else if (an_s > an_hi) begin
                    upd_val = `TSR_AN_HI;
                end else begin
                    upd_val = sample_data;
                end
            end else if (sample_open) begin
                upd      = 1'b1;
                upd_val  = `TSR_CODE_TC_OPEN;
                upd_open = 1'b1;
            end else if (temp_x >= lo_x && temp_x <= hi_x) begin
                upd     = 1'b1;
                upd_val = temp_x[15:0];
            end
            // Else past the margin: word is held
        end
    end

    // ****************************************
    // Result words
    // ****************************************
    reg [15:0] result [0:3];
    reg [3:0]  open_st;
    reg [3:0]  open_rise;

    // Whole word written in one edge, never piecewise
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_res
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    result[gi]    <= `TSR_CODE_START;
                    open_st[gi]   <= 1'b0;
                    open_rise[gi] <= 1'b0;
                end else begin
                    open_rise[gi] <= 1'b0;
                    if (upd && conv_chan == gi) begin
                        result[gi]    <= upd_val;
                        open_st[gi]   <= upd_open;
                        open_rise[gi] <= upd_open & ~open_st[gi];
                    end
                end
            end
        end
    endgenerate

    reg pass_done;

    // Pass ends with channel 3 sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pass_done <= 1'b0;
        else
            pass_done <= state == ST_WAIT && sample_valid &&
                         conv_chan == 2'd3;
    end

    // ****************************************
    // APB slave
    // ****************************************
    reg  [4:0] status;
    reg  [4:0] mask;
    wire       setup   = psel & ~penable;
    wire       access  = psel & penable;
    reg        mapped;

    // Zero-wait slave: read data is sampled in setup so it comes from a
    // flop yet is ready in the access phase
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    always @* begin
        case (paddr)
            `TSR_OFF_CH0, `TSR_OFF_CH1, `TSR_OFF_CH2, `TSR_OFF_CH3,
            `TSR_OFF_STATUS, `TSR_OFF_MASK, `TSR_OFF_CONFIG:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // Read data capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            case (paddr)
                `TSR_OFF_CH0:    prdata <= {16'h0000, result[0]};
                `TSR_OFF_CH1:    prdata <= {16'h0000, result[1]};
                `TSR_OFF_CH2:    prdata <= {16'h0000, result[2]};
                `TSR_OFF_CH3:    prdata <= {16'h0000, result[3]};
                `TSR_OFF_STATUS: prdata <= {27'h0000000, status};
                `TSR_OFF_MASK:   prdata <= {27'h0000000, mask};
                `TSR_OFF_CONFIG: prdata <= {26'h0000000, started, cfg};
                default:         prdata <= 32'h00000000;
            endcase
        end
    end

    // Mask register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mask <= `TSR_MASK_RST;
        else if (access && pwrite && paddr == `TSR_OFF_MASK)
            mask <= pwdata[4:0];
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    wire [4:0] ev_set;
    wire       st_clr;
    wire [4:0] clr_bits;

    assign ev_set   = {pass_done, open_rise};
    assign st_clr   = access & ~pwrite & (paddr == `TSR_OFF_STATUS);
    assign clr_bits = st_clr ? prdata[4:0] : 5'h00;

    // Read clears only the bits it returned, so an event landing on the
    // setup edge is not lost; an event in the clear cycle survives too
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status <= `TSR_STATUS_RST;
        else
            status <= (status & ~clr_bits) | ev_set;
    end

    assign irq = |(status & mask);

endmodule // tsr_readout

// *** tsr_readout_assertions.sv ***
`timescale 1ns/100ps
// ***********************************
// Port checker
// ***********************************
module tsr_readout_checker #(
    parameter PASS_CYCLES  = 40,
    parameter START_CYCLES = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        conv_start,
    input wire [1:0]  conv_chan,
    input wire        conv_analog,
    input wire        conv_type_j,
    input wire        conv_live_zero
);
    reg [31:0] since_rst;
    reg [31:0] since_start;
    reg        seen;
    // Counters give the slot spacing without long repetitions
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rst   <= 32'h0;
            since_start <= 32'h0;
            seen        <= 1'b0;
        end else begin
            since_rst   <= since_rst + 32'h1;
            since_start <= conv_start ? 32'h1 : since_start + 32'h1;
            seen        <= seen | conv_start;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err;
        s_access and paddr > 8'h18 |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slverr");
    property p_ok;
        s_access and paddr <= 8'h18 and paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("slverr on map");
    property p_err_data;
        s_access and !pwrite and pslverr |-> prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("err data");
    property p_read_holds;
        s_setup ##1 s_access ##1 !psel |-> $stable(prdata);
    endproperty
    a_read_holds: assert property (p_read_holds) else $error("rd moved");
    property p_upper_zero;
        s_setup ##1 (s_access and !pwrite and paddr < 8'h10)
            |-> prdata[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("hi bits");
    property p_pulse; conv_start |=> !conv_start; endproperty
    a_pulse: assert property (p_pulse) else $error("long start");
    property p_order;
        conv_start |-> conv_chan == $past(conv_chan) + 2'd1;
    endproperty
    a_order: assert property (p_order) else $error("chan order");
    property p_slot;
        conv_start && seen |-> since_start == PASS_CYCLES / 4;
    endproperty
    a_slot: assert property (p_slot) else $error("slot length");
    property p_first;
        conv_start && !seen |-> since_rst >= START_CYCLES;
    endproperty
    a_first: assert property (p_first) else $error("early start");
    property p_tc; conv_start && !conv_chan[1] |-> !conv_analog; endproperty
    a_tc: assert property (p_tc) else $error("analog on ch0/1");
    property p_cfg;
        seen |-> $stable(conv_type_j) && $stable(conv_live_zero);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config moved");
endmodule // tsr_readout_checker

bind tsr_readout tsr_readout_checker #(
    .PASS_CYCLES(PASS_CYCLES), .START_CYCLES(START_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_analog(conv_analog), .conv_type_j(conv_type_j),
    .conv_live_zero(conv_live_zero)
);

// *** tsr_front_end_model.sv ***
`timescale 1ns/100ps
// ***********************************
// Converter front end
// ***********************************
module tsr_front_end_model (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        conv_start,
    input  wire [1:0]  conv_chan,
    input  wire        slow,
    input  wire [63:0] data_all,
    input  wire [3:0]  open_all,
    output reg         sample_valid,
    output reg         sample_open,
    output reg  [15:0] sample_data
);
    reg       busy;
    reg [1:0] ch;
    reg [3:0] wait_cnt;
    // One sample per request; lines toggle outside the valid cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy         <= 1'b0;
            ch           <= 2'd0;
            wait_cnt     <= 4'd0;
            sample_valid <= 1'b0;
            sample_open  <= 1'b0;
            sample_data  <= 16'h0000;
        end else if (conv_start) begin
            busy     <= 1'b1;
            ch       <= conv_chan;
            wait_cnt <= slow ? 4'd6 : 4'd1;
        end else if (busy && wait_cnt == 4'd0) begin
            busy         <= 1'b0;
            sample_valid <= 1'b1;
            sample_open  <= open_all[ch];
            sample_data  <= data_all[ch*16 +: 16];
        end else begin
            wait_cnt     <= busy ? wait_cnt - 4'd1 : wait_cnt;
            sample_valid <= 1'b0;
            sample_open  <= ~sample_open;
            sample_data  <= ~sample_data;
        end
    end
endmodule // tsr_front_end_model

// *** tsr_readout_test.sv ***
`timescale 1ns/100ps
`include "tsr_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
// ***********************************
// Bench
// ***********************************
module tsr_readout_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0]  sw = 5'h00;
    logic        slow = 1'b0;
    logic [63:0] fe_data = 64'h0;
    logic [3:0]  fe_open = 4'h0;
    wire         pready, pslverr, irq, conv_start, conv_analog;
    wire         conv_type_j, conv_live_zero, sample_valid, sample_open;
    wire  [1:0]  conv_chan;
    wire  [15:0] sample_data;
    wire  [31:0] prdata;
    logic [31:0] rdata;
    logic        rerr;
    int          mismatches = 0;
    int          num_checks = 0;

    always #2 pclk = ~pclk;

    tsr_readout #(.PASS_CYCLES(40), .START_CYCLES(20)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .thermocouple_type_switch(sw[0]), .temperature_unit_switch(sw[1]),
        .channel2_input_type_switch(sw[2]),
        .channel3_input_type_switch(sw[3]), .analog_range_switch(sw[4]),
        .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_analog(conv_analog), .conv_type_j(conv_type_j),
        .conv_live_zero(conv_live_zero), .sample_valid(sample_valid),
        .sample_open(sample_open), .sample_data(sample_data));

    tsr_front_end_model u_fe (
        .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_chan(conv_chan), .slow(slow), .data_all(fe_data),
        .open_all(fe_open), .sample_valid(sample_valid),
        .sample_open(sample_open), .sample_data(sample_data));

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Setup, access until pready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdata)
    endtask

    // Channel 0 first: later words refresh later in the pass
    task automatic results(input logic [63:0] e);
        for (int i = 0; i < 4; i++)
            rd("result", 8'(i * 4), {16'h0, e[i*16 +: 16]});
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            conclude();
        end
    endtask

    // Switches move only while reset is held
    task automatic do_reset(input logic [4:0] s);
        presetn <= 1'b0;
        sw <= s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    initial begin
        fe_data <= {16'h32c8, 16'hfd44, 16'h0000, 16'h1388};
        fe_open <= 4'b0010;
        do_reset(5'b11100);
        rd("startup", `TSR_OFF_CH0, {16'h0, `TSR_CODE_START});
        apb(1'b1, `TSR_OFF_CH0, 32'h1234);
        rd("ro", `TSR_OFF_CH0, {16'h0, `TSR_CODE_START});
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("slverr", 1'b1, rerr)
        `CHK("slvdata", 32'h0, rdata)
        apb(1'b1, `TSR_OFF_MASK, 32'h10);
        rd("mask", `TSR_OFF_MASK, 32'h10);
        wait_irq();
        fe_data <= {16'hfce0, 16'hfda8, 16'hf830, 16'h33f4};
        fe_open <= 4'b0000;
        results({16'h3138, 16'h8000, 16'h7fff, 16'h1388});
        rd("status", `TSR_OFF_STATUS, 32'h16);
        rd("clear", `TSR_OFF_STATUS, 32'h0);
        `CHK("irq_low", 1'b0, irq)
        wait_irq();
        results({16'h8000, 16'hfda8, 16'hf830, 16'h1388});
        rd("status2", `TSR_OFF_STATUS, 32'h18);
        rd("cfg", `TSR_OFF_CONFIG, 32'h3c);
        slow <= 1'b1;
        fe_data <= {16'hfd44, 16'hff9c, 16'h2134, 16'h03e8};
        do_reset(5'b01011);
        rd("mask_rst", `TSR_OFF_MASK, 32'h0);
        repeat (120) begin
            @(posedge pclk);
            `CHK("masked", 1'b0, irq)
        end
        rd("status3", `TSR_OFF_STATUS, 32'h10);
        rd("cfg2", `TSR_OFF_CONFIG, 32'h2b);
        apb(1'b1, `TSR_OFF_MASK, 32'h10);
        wait_irq();
        results({16'hfda8, 16'h008c, 16'h7ffe, 16'h0848});
        conclude();
    end
endmodule // tsr_readout_test
